// >>> hw/fcr_config_regs.v
// Purpose: boot and runtime configuration registers behind the serial command port
// Assumes: mode 0 framing, sclk well below mclk/4, single data line
// Notes: array data arrives on mem_rdata for the address on mem_addr
`timescale 1ns/10ps
`default_nettype none
`include "fcr_defs.vh"

module fcr_config_regs #(
    parameter BOOT_INIT = `FCR_BOOT_RESET,
    parameter XIP_FORCED = 0,
    parameter BUSY_CYC = `FCR_BOOT_WRITE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Serial link
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    output reg miso,
    output reg miso_oe,
    // Array read port
    output reg [23:0] mem_addr,
    input wire [7:0] mem_rdata,
    // Working configuration
    output reg [3:0] cfg_dummy,
    output reg xip_active,
    output reg [2:0] cfg_xip_mode,
    output reg [2:0] cfg_drive,
    output reg cfg_hold_en,
    output reg cfg_quad,
    output reg cfg_dual,
    output reg [1:0] cfg_wrap,
    output reg wip
);

    localparam ST_CMD = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_DUMMY = 3'h2;
    localparam ST_OUT = 3'h3;
    localparam ST_WDATA = 3'h4;
    localparam ST_IGN = 3'h5;

    localparam SRC_STAT = 2'h0;
    localparam SRC_RUN = 2'h1;
    localparam SRC_BOOT = 2'h2;
    localparam SRC_ARRAY = 2'h3;

    // ==========================================================
    // Dummy code to clock count
    function [3:0] dummy_count;
        input [3:0] code;
        begin
            if (code == `FCR_DUMMY_ZERO || code == `FCR_DUMMY_MAX) begin
                dummy_count = `FCR_DUMMY_DEFAULT;
            end else begin
                dummy_count = code;
            end
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    reg [2:0] sclk_s;
    reg [2:0] cs_s;
    reg [1:0] mosi_s;
    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];
    wire sel = ~cs_s[1];
    wire cs_rise = cs_s[1] & ~cs_s[2];
    wire din = mosi_s[1];

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            mosi_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            cs_s <= {cs_s[1:0], cs_n};
            mosi_s <= {mosi_s[0], mosi};
        end
    end

    // ==========================================================
    // Registers and engine state
    reg [15:0] boot_configuration;
    reg [7:0] runtime_configuration;
    reg [15:0] boot_pend;
    reg boot_load;
    reg wel;
    reg [11:0] busy_cnt;
    reg [2:0] state;
    reg [4:0] bitcnt;
    reg [3:0] dcnt;
    reg [7:0] shift;
    reg [7:0] op;
    reg [7:0] out_byte;
    reg [1:0] src;
    reg boot_hi;
    reg [15:0] wbuf;
    reg [1:0] nbytes;
    wire [7:0] next_byte = {shift[6:0], din};
    wire [7:0] status = {6'h00, wel, wip};
    wire [23:0] next_addr;

    fcr_wrap_next #(
        .AW(24)
    ) u_wrap (
        .addr(mem_addr),
        .wrap(cfg_wrap),
        .next_addr(next_addr)
    );

    // ==========================================================
    // Working configuration outputs
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_dummy <= `FCR_DUMMY_DEFAULT;
            xip_active <= 1'b0;
            cfg_wrap <= `FCR_WRAP_SEQ;
        end else begin
            cfg_dummy <= dummy_count(runtime_configuration[`FCR_RUN_DUMMY_HI:`FCR_RUN_DUMMY_LO]);
            xip_active <= (XIP_FORCED != 0) | ~runtime_configuration[`FCR_RUN_XIP];
            cfg_wrap <= runtime_configuration[`FCR_RUN_WRAP_HI:`FCR_RUN_WRAP_LO];
        end
    end

    // ==========================================================
    // Boot load, register writes and commit timer
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            boot_configuration <= BOOT_INIT;
            runtime_configuration <= 8'hFB;
            boot_pend <= 16'hFFFF;
            boot_load <= 1'b1;
            wel <= 1'b0;
            wip <= 1'b0;
            busy_cnt <= 12'h000;
            cfg_xip_mode <= `FCR_XIP_OFF;
            cfg_drive <= 3'h7;
            cfg_hold_en <= 1'b1;
            cfg_quad <= 1'b0;
            cfg_dual <= 1'b0;
        end else begin
            if (boot_load) begin
                // Reset copy only; later boot writes never reach the working setting, since reset reloads BOOT_INIT
                boot_load <= 1'b0;
                runtime_configuration <= {
                    boot_configuration[`FCR_BOOT_DUMMY_HI:`FCR_BOOT_DUMMY_LO],
                    boot_configuration[`FCR_BOOT_XIP_HI:`FCR_BOOT_XIP_LO] == `FCR_XIP_OFF,
                    1'b0,
                    `FCR_WRAP_SEQ};
                cfg_xip_mode <= boot_configuration[`FCR_BOOT_XIP_HI:`FCR_BOOT_XIP_LO];
                cfg_drive <= boot_configuration[`FCR_BOOT_DRV_HI:`FCR_BOOT_DRV_LO];
                cfg_hold_en <= boot_configuration[`FCR_BOOT_HOLD];
                cfg_quad <= ~boot_configuration[`FCR_BOOT_QUAD];
                cfg_dual <= ~boot_configuration[`FCR_BOOT_DUAL] & boot_configuration[`FCR_BOOT_QUAD];
            end
            if (busy_cnt != 12'h000) begin
                busy_cnt <= busy_cnt - 12'h001;
                if (busy_cnt == 12'h001) begin
                    boot_configuration <= boot_pend;
                    wip <= 1'b0;
                    wel <= 1'b0;
                end
            end else if (cs_rise && !boot_load) begin
                // Commands act when the frame closes
                if (op == `FCR_CMD_WREN && state == ST_IGN) begin
                    wel <= 1'b1;
                end else if (op == `FCR_CMD_WRRUN && state == ST_WDATA && nbytes == 2'h1 && wel) begin
                    runtime_configuration <= {wbuf[7:3], 1'b0, wbuf[1:0]};
                    wel <= 1'b0;
                end else if (op == `FCR_CMD_WRBOOT && state == ST_WDATA && nbytes == 2'h2 && wel) begin
                    boot_pend <= {wbuf[7:0], wbuf[15:8]};
                    busy_cnt <= BUSY_CYC[11:0];
                    wip <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Serial command engine
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_CMD;
            bitcnt <= 5'h00;
            dcnt <= 4'h0;
            shift <= 8'h00;
            op <= 8'h00;
            out_byte <= 8'h00;
            src <= SRC_STAT;
            boot_hi <= 1'b0;
            wbuf <= 16'h0000;
            nbytes <= 2'h0;
            mem_addr <= 24'h000000;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else if (!sel) begin
            state <= ST_CMD;
            bitcnt <= 5'h00;
            miso_oe <= 1'b0;
        end else if (sclk_rise) begin
            shift <= next_byte;
            case (state)
                ST_CMD: begin
                    if (bitcnt[2:0] == 3'h7) begin
                        op <= next_byte;
                        bitcnt <= 5'h00;
                        nbytes <= 2'h0;
                        boot_hi <= 1'b0;
                        if (next_byte == `FCR_CMD_RDSR) begin
                            state <= ST_OUT;
                            src <= SRC_STAT;
                            out_byte <= status;
                        end else if (wip || boot_load) begin
                            // Only status polling while the boot write commits
                            state <= ST_IGN;
                        end else if (next_byte == `FCR_CMD_RDBOOT) begin
                            state <= ST_OUT;
                            src <= SRC_BOOT;
                            out_byte <= boot_configuration[7:0];
                        end else if (next_byte == `FCR_CMD_RDRUN) begin
                            state <= ST_OUT;
                            src <= SRC_RUN;
                            out_byte <= runtime_configuration;
                        end else if (next_byte == `FCR_CMD_WRRUN || next_byte == `FCR_CMD_WRBOOT) begin
                            state <= ST_WDATA;
                        end else if (next_byte == `FCR_CMD_FREAD) begin
                            state <= ST_ADDR;
                        end else begin
                            state <= ST_IGN;
                        end
                    end else begin
                        bitcnt <= bitcnt + 5'h01;
                    end
                end
                ST_ADDR: begin
                    mem_addr <= {mem_addr[22:0], din};
                    if (bitcnt == 5'h17) begin
                        bitcnt <= 5'h00;
                        dcnt <= 4'h1;
                        state <= ST_DUMMY;
                    end else begin
                        bitcnt <= bitcnt + 5'h01;
                    end
                end
                ST_DUMMY: begin
                    if (dcnt == cfg_dummy) begin
                        // Last dummy clock: first byte from the start address
                        state <= ST_OUT;
                        src <= SRC_ARRAY;
                        out_byte <= mem_rdata;
                        mem_addr <= next_addr;
                    end else begin
                        dcnt <= dcnt + 4'h1;
                    end
                end
                ST_OUT: begin
                    bitcnt <= {2'h0, bitcnt[2:0] + 3'h1};
                    if (bitcnt[2:0] == 3'h7) begin
                        case (src)
                            SRC_STAT: out_byte <= status;
                            SRC_RUN: out_byte <= runtime_configuration;
                            SRC_BOOT: begin
                                out_byte <= boot_hi ? boot_configuration[7:0] : boot_configuration[15:8];
                                boot_hi <= ~boot_hi;
                            end
                            default: begin
                                out_byte <= mem_rdata;
                                mem_addr <= next_addr;
                            end
                        endcase
                    end
                end
                ST_WDATA: begin
                    if (bitcnt[2:0] == 3'h7) begin
                        wbuf <= {wbuf[7:0], next_byte};
                        if (nbytes != 2'h3) begin
                            nbytes <= nbytes + 2'h1;
                        end
                    end
                    bitcnt <= {2'h0, bitcnt[2:0] + 3'h1};
                end
                default: begin
                    bitcnt <= 5'h00;
                end
            endcase
        end else if (sclk_fall && state == ST_OUT) begin
            // Data moves on the falling edge so the host samples it on the rising one
            miso <= out_byte[3'h7 - bitcnt[2:0]];
            miso_oe <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> hw/fcr_defs.vh
// Purpose: shared constants of the flash configuration register block
// Assumes: single-line serial framing, mode 0, bytes sent MSB first
// Notes: times in ns, cycle counts derived from the 4 ns system clock
`ifndef FCR_DEFS_VH
`define FCR_DEFS_VH

// ==========================================================
// Commands
`define FCR_CMD_WREN 8'h06
`define FCR_CMD_RDSR 8'h05
`define FCR_CMD_FREAD 8'h0B
`define FCR_CMD_RDBOOT 8'hB5
`define FCR_CMD_WRBOOT 8'hB1
`define FCR_CMD_RDRUN 8'h85
`define FCR_CMD_WRRUN 8'h81

// ==========================================================
// Boot register fields
`define FCR_BOOT_RESET 16'hFFFF
`define FCR_BOOT_DUMMY_HI 15
`define FCR_BOOT_DUMMY_LO 12
`define FCR_BOOT_XIP_HI 11
`define FCR_BOOT_XIP_LO 9
`define FCR_BOOT_DRV_HI 8
`define FCR_BOOT_DRV_LO 6
`define FCR_BOOT_HOLD 4
`define FCR_BOOT_QUAD 3
`define FCR_BOOT_DUAL 2
`define FCR_XIP_OFF 3'h7

// ==========================================================
// Runtime register fields
`define FCR_RUN_DUMMY_HI 7
`define FCR_RUN_DUMMY_LO 4
`define FCR_RUN_XIP 3
`define FCR_RUN_RSVD 2
`define FCR_RUN_WRAP_HI 1
`define FCR_RUN_WRAP_LO 0
`define FCR_WRAP_16 2'h0
`define FCR_WRAP_32 2'h1
`define FCR_WRAP_64 2'h2
`define FCR_WRAP_SEQ 2'h3

// ==========================================================
// Dummy encoding and timing
`define FCR_DUMMY_ZERO 4'h0
`define FCR_DUMMY_MAX 4'hF
`define FCR_DUMMY_DEFAULT 4'hA
`define FCR_CLK_PERIOD_NS 4
`define FCR_BOOT_WRITE_NS 2000
`define FCR_BOOT_WRITE_CYC ((`FCR_BOOT_WRITE_NS + `FCR_CLK_PERIOD_NS - 1) / `FCR_CLK_PERIOD_NS)

`endif

// >>> hw/fcr_wrap_next.v
// Purpose: next array address of a read burst under the wrap setting
// Assumes: address width at least 6 bits
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "fcr_defs.vh"

module fcr_wrap_next #(
    parameter AW = 24
) (
    // Current address and wrap code
    input wire [AW-1:0] addr,
    input wire [1:0] wrap,
    // Following address
    output reg [AW-1:0] next_addr
);

    reg [AW-1:0] mask;
    reg [AW-1:0] inc;

    // ==========================================================
    // Increment inside the aligned block for the 16, 32 and 64 byte wraps; sequential increments the whole address
    always @* begin
        inc = addr + {{(AW-1){1'b0}}, 1'b1};
        case (wrap)
            `FCR_WRAP_16: mask = {{(AW-4){1'b0}}, 4'hF};
            `FCR_WRAP_32: mask = {{(AW-5){1'b0}}, 5'h1F};
            `FCR_WRAP_64: mask = {{(AW-6){1'b0}}, 6'h3F};
            default: mask = {AW{1'b1}};
        endcase
        next_addr = (addr & ~mask) | (inc & mask);
    end

endmodule
`default_nettype wire

// >>> sim/fcr_config_monitor.sv
// Purpose: port-level checker of the configuration register block
// Assumes: single mclk domain, rstn active low
// Notes: bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
module fcr_config_monitor #(
    parameter logic [15:0] BOOT_INIT = 16'hFFFF,
    parameter XIP_FORCED = 0,
    parameter int BUSY_CYC = 500
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    // Array port
    input wire logic [23:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // Working configuration
    input wire logic [3:0] cfg_dummy,
    input wire logic xip_active,
    input wire logic [2:0] cfg_xip_mode,
    input wire logic [2:0] cfg_drive,
    input wire logic cfg_hold_en,
    input wire logic cfg_quad,
    input wire logic cfg_dual,
    input wire logic [1:0] cfg_wrap,
    input wire logic wip
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // Busy length counter
    int wip_cnt;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) wip_cnt <= 0;
        else wip_cnt <= wip ? wip_cnt + 1 : 0;
    end
    // ==========================================
    // Assertions
    a_dummy_legal: assert property (cfg_dummy != 4'h0 && cfg_dummy != 4'hF)
        else $error("dummy count shows a raw default code");
    a_boot_load: assert property ($past(rstn, 4) |-> cfg_xip_mode == BOOT_INIT[11:9]
        && cfg_drive == BOOT_INIT[8:6] && cfg_hold_en == BOOT_INIT[4])
        else $error("boot fields not loaded");
    a_quad_dual: assert property ($past(rstn, 4) |-> cfg_quad == !BOOT_INIT[3]
        && cfg_dual == (BOOT_INIT[3] && !BOOT_INIT[2])) else $error("line protocol wrong");
    a_run_at_cs: assert property ($changed({cfg_dummy, xip_active, cfg_wrap}) |-> cs_n)
        else $error("runtime setting changed inside a frame");
    a_wip_freeze: assert property (wip |-> $stable(cfg_dummy) && $stable(cfg_wrap))
        else $error("working setting moved during commit");
    a_wip_after_cs: assert property ($rose(wip) |-> cs_n)
        else $error("busy rose inside a frame");
    a_wip_length: assert property ($fell(wip) |->
        wip_cnt >= BUSY_CYC - 1 && wip_cnt <= BUSY_CYC + 1) else $error("busy length wrong");
    a_oe_release: assert property (cs_n [*8] |-> !miso_oe)
        else $error("miso driven outside a frame");
    cover property ($rose(wip));
    cover property ($changed(cfg_wrap));
    cover property ($rose(miso_oe));
endmodule
bind fcr_config_regs fcr_config_monitor #(.BOOT_INIT(BOOT_INIT), .XIP_FORCED(XIP_FORCED),
    .BUSY_CYC(BUSY_CYC)) u_mon (.mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .cfg_dummy(cfg_dummy), .xip_active(xip_active), .cfg_xip_mode(cfg_xip_mode),
    .cfg_drive(cfg_drive), .cfg_hold_en(cfg_hold_en), .cfg_quad(cfg_quad),
    .cfg_dual(cfg_dual), .cfg_wrap(cfg_wrap), .wip(wip));
`default_nettype wire

// >>> sim/fcr_host_model.sv
// Purpose: serial host that frames commands, mode 0, MSB first
// Assumes: sclk of 80 ns made from 20 mclk cycles
// Notes: sclk stands low between frames
`timescale 1ns/10ps
`default_nettype none
module fcr_host_model (
    // Clock
    input wire logic mclk,
    // Serial link
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic open_frame();
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask
    // Data set in low phase, miso taken at the rising edge
    task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            mosi <= tx[7];
            tx = tx << 1;
            repeat (10) @(posedge mclk);
            sclk <= 1'b1;
            rx = {rx[6:0], miso};
            repeat (10) @(posedge mclk);
            sclk <= 1'b0;
        end
    endtask
    // Released line shows the inverse, never a stale level
    task automatic close_frame();
        repeat (10) @(posedge mclk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the configuration register block
// Assumes: host model drives the serial link
// Notes: second instance only proves boot-time loading
`timescale 1ns/10ps
`default_nettype none
`include "fcr_defs.vh"
module tb_top;
    logic mclk, rstn;
    wire sclk, cs_n, mosi, miso, xact, hold, quad, dual, wip, bx, bh, bq, bd;
    wire [23:0] mem_addr;
    wire [3:0] dummy, bdm;
    wire [2:0] xmode, drv, bm, bdr;
    wire [1:0] wrap, bw;
    wire [7:0] mem_rdata = mem_addr[7:0] ^ 8'hA5;
    wire [23:0] cfg_v = {7'h00, dummy, xact, xmode, drv, hold, quad, dual, wrap, wip};
    wire [23:0] cfg_b = {7'h00, bdm, bx, bm, bdr, bh, bq, bd, bw, 1'b0};
    int n_errors = 0, checked = 0, cycles = 0;
    logic [15:0] v;
    logic [7:0] r;
    fcr_config_regs #(.BUSY_CYC(1000)) u_dut (.mclk(mclk), .rstn(rstn), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .cfg_dummy(dummy), .xip_active(xact), .cfg_xip_mode(xmode),
        .cfg_drive(drv), .cfg_hold_en(hold), .cfg_quad(quad), .cfg_dual(dual),
        .cfg_wrap(wrap), .wip(wip));
    // Shares the link so its framing sees the same traffic; only boot loading is judged
    fcr_config_regs #(.BOOT_INIT(16'h3040)) u_dut_boot (.mclk(mclk), .rstn(rstn),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(), .miso_oe(), .mem_addr(),
        .mem_rdata(mem_rdata), .cfg_dummy(bdm), .xip_active(bx), .cfg_xip_mode(bm),
        .cfg_drive(bdr), .cfg_hold_en(bh), .cfg_quad(bq), .cfg_dual(bd), .cfg_wrap(bw),
        .wip());
    fcr_host_model u_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] op, input logic [15:0] d, input int nb);
        u_host.open_frame();
        u_host.shift(8, op, r);
        if (nb > 0) u_host.shift(8, d[7:0], r);
        if (nb > 1) u_host.shift(8, d[15:8], r);
        u_host.close_frame();
    endtask
    task automatic rd(input logic [7:0] op, output logic [15:0] d);
        u_host.open_frame();
        u_host.shift(8, op, r);
        u_host.shift(8, 8'h00, d[7:0]);
        u_host.shift(8, 8'h00, d[15:8]);
        u_host.close_frame();
    endtask
    task automatic wrun(input logic [7:0] d);
        send(`FCR_CMD_WREN, 16'h0000, 0);
        send(`FCR_CMD_WRRUN, {8'h00, d}, 1);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk(cfg_v, {7'h00, 4'hA, 1'b0, 3'h7, 3'h7, 1'b1, 1'b0, 1'b0, 2'h3, 1'b0});
        chk(cfg_b, {7'h00, 4'h3, 1'b1, 3'h0, 3'h1, 1'b0, 1'b1, 1'b0, 2'h3, 1'b0});
        rd(`FCR_CMD_RDBOOT, v);
        chk({8'h00, v}, 24'h00FFFF);
    endtask
    task automatic t_runtime();
        send(`FCR_CMD_WRRUN, 16'h0050, 1);
        chk({22'h0, wrap}, 24'h3);
        wrun(8'h50);
        chk(cfg_v, {7'h00, 4'h5, 1'b1, 3'h7, 3'h7, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0});
        rd(`FCR_CMD_RDRUN, v);
        chk({8'h00, v}, 24'h005050);
        wrun(8'h0B);
        chk({19'h0, dummy, xact}, {19'h0, 4'hA, 1'b0});
    endtask
    task automatic t_wrap();
        logic [23:0] e, sz;
        for (int w = 0; w < 4; w++) begin
            wrun({4'h5, 2'b00, w[1:0]});
            // Start on the last byte of every block size so each wrap length shows
            e = 24'h00003F;
            sz = 24'h10 << w;
            u_host.open_frame();
            u_host.shift(8, `FCR_CMD_FREAD, r);
            u_host.shift(8, 8'h00, r);
            u_host.shift(8, 8'h00, r);
            u_host.shift(8, 8'h3F, r);
            u_host.shift(5, 8'h00, r);
            for (int k = 0; k < 3; k++) begin
                u_host.shift(8, 8'h00, r);
                chk({16'h0, r}, {16'h0, e[7:0] ^ 8'hA5});
                e = e + 1;
                if (w != 3 && (e % sz) == 24'h0) e = e - sz;
            end
            u_host.close_frame();
        end
    endtask
    task automatic t_boot_write();
        int n;
        send(`FCR_CMD_WREN, 16'h0000, 0);
        send(`FCR_CMD_WRBOOT, 16'h3040, 2);
        rd(`FCR_CMD_RDSR, v);
        chk({22'h0, v[8], v[0]}, 24'h3);
        n = 0;
        while (wip !== 1'b0 && n < 1500) begin
            @(posedge mclk);
            n++;
        end
        chk({20'h0, dummy}, 24'h5);
        rd(`FCR_CMD_RDBOOT, v);
        chk({8'h00, v}, 24'h003040);
    endtask
    initial begin
        rstn = 1'b0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (12) @(posedge mclk);
        t_reset();
        t_runtime();
        t_wrap();
        t_boot_write();
        conclude();
    end
endmodule
`default_nettype wire
